/* rtl/modulator_carrier_select.sv */
// carrier selection, inversion and synchronised switching for the modulator
//
// Function
// - low carrier is inverted when its invert bit is one, else passed
// - low sync set: switch low to high only at low carrier falling edge
// - without sync, shortened pulses at switch points are acceptable
// - unimplemented register bits, including carrier bit 4, read zero
// - high sync set: switch high to low only at high carrier falling edge
// - select code: 0 ground, 4..7 pwm units, 8..15 nothing connected
//
// The plain strobed port and the register addresses were decided locally.
`default_nettype none
module modulator_carrier_select (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] carrier_sources,
    input wire logic modulation_in,
    output logic carrier_out,
    output logic modulated_out,
    output logic [15:0] source_pin_drive_allow
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] reset_sync;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reset_sync <= 2'h0;
        end else begin
            reset_sync <= {reset_sync[0], 1'b1};
        end
    end
    assign rst_n = reset_sync[1];

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic pick_source(input logic [3:0] sel, input logic [15:0] src);
        logic result;
        result = 1'b0;
        if (sel == modulator_pkg::select_ground || sel >= modulator_pkg::select_none_first) begin
            result = 1'b0;
        end else begin
            result = src[sel];
        end
        return result;
    endfunction : pick_source

    function automatic logic [15:0] pin_allow(input modulator_pkg::carrier_ctrl_s c);
        logic [15:0] mask;
        mask = 16'hffff;
        if (c.pin_disable && c.select != modulator_pkg::select_ground
                && c.select < modulator_pkg::select_none_first) begin
            mask[c.select] = 1'b0;
        end
        return mask;
    endfunction : pin_allow

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    modulator_pkg::reg_req_s req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, write: reg_write, read: reg_read};

    logic [7:0] mod_control;
    logic [7:0] source_select;
    modulator_pkg::carrier_ctrl_s high_ctrl;
    modulator_pkg::carrier_ctrl_s low_ctrl;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mod_control <= modulator_pkg::register_reset;
            source_select <= modulator_pkg::register_reset;
            high_ctrl <= modulator_pkg::register_reset;
            low_ctrl <= modulator_pkg::register_reset;
        end else if (clk_en && req.write) begin
            case (req.addr)
                modulator_pkg::mod_control_offset: begin
                    mod_control <= req.wdata & modulator_pkg::control_implemented_mask;
                end
                modulator_pkg::source_select_offset: begin
                    source_select <= req.wdata & modulator_pkg::source_implemented_mask;
                end
                modulator_pkg::high_carrier_offset: begin
                    high_ctrl <= req.wdata & modulator_pkg::carrier_implemented_mask;
                end
                modulator_pkg::low_carrier_offset: begin
                    low_ctrl <= req.wdata & modulator_pkg::carrier_implemented_mask;
                end
                default: begin
                end
            endcase
        end
    end

    logic [7:0] next_rdata;
    logic [7:0] status_view;
    always_comb begin
        status_view = mod_control;
        status_view[modulator_pkg::output_level_bit] = modulated_out;
        case (req.addr)
            modulator_pkg::mod_control_offset: next_rdata = status_view;
            modulator_pkg::source_select_offset: next_rdata = source_select;
            modulator_pkg::high_carrier_offset: next_rdata = high_ctrl;
            modulator_pkg::low_carrier_offset: next_rdata = low_ctrl;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= req.read ? next_rdata : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // carrier conditioning
    // ------------------------------------------------------------
    logic high_carrier;
    logic low_carrier;
    logic high_prev;
    logic low_prev;
    logic modulation;
    assign high_carrier = pick_source(high_ctrl.select, carrier_sources) ^ high_ctrl.invert;
    assign low_carrier = pick_source(low_ctrl.select, carrier_sources) ^ low_ctrl.invert;
    assign modulation = source_select[3:0] == 4'h0 ? mod_control[modulator_pkg::software_bit]
                                                   : modulation_in;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            high_prev <= 1'b0;
            low_prev <= 1'b0;
        end else if (clk_en) begin
            high_prev <= high_carrier;
            low_prev <= low_carrier;
        end
    end

    logic high_fall;
    logic low_fall;
    assign high_fall = high_prev && !high_carrier;
    assign low_fall = low_prev && !low_carrier;

    // ------------------------------------------------------------
    // carrier switch state
    // ------------------------------------------------------------
    modulator_pkg::carrier_state_e state;
    modulator_pkg::carrier_state_e next_state;
    always_comb begin
        next_state = state;
        case (state)
            modulator_pkg::use_low: begin
                if (modulation) begin
                    next_state = low_ctrl.sync ? modulator_pkg::wait_low_fall
                                               : modulator_pkg::use_high;
                end
            end
            modulator_pkg::wait_low_fall: begin
                if (!modulation) begin
                    next_state = modulator_pkg::use_low;
                end else if (low_fall || !low_ctrl.sync) begin
                    next_state = modulator_pkg::use_high;
                end
            end
            modulator_pkg::use_high: begin
                if (!modulation) begin
                    next_state = high_ctrl.sync ? modulator_pkg::wait_high_fall
                                                : modulator_pkg::use_low;
                end
            end
            modulator_pkg::wait_high_fall: begin
                if (modulation) begin
                    next_state = modulator_pkg::use_high;
                end else if (high_fall || !high_ctrl.sync) begin
                    next_state = modulator_pkg::use_low;
                end
            end
            default: next_state = modulator_pkg::use_low;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= modulator_pkg::use_low;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic next_carrier;
    // unsynchronised switch may cut a pulse short
    assign next_carrier = (next_state == modulator_pkg::use_high
                           || next_state == modulator_pkg::wait_high_fall)
                          ? high_carrier : low_carrier;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            carrier_out <= 1'b0;
            modulated_out <= 1'b0;
        end else if (clk_en) begin
            carrier_out <= next_carrier;
            modulated_out <= mod_control[modulator_pkg::enable_bit]
                             && (next_carrier ^ mod_control[modulator_pkg::output_invert_bit]);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            source_pin_drive_allow <= 16'hffff;
        end else if (clk_en) begin
            source_pin_drive_allow <= pin_allow(low_ctrl) & pin_allow(high_ctrl);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence low_wait_s;
        state == modulator_pkg::wait_low_fall && modulation && low_ctrl.sync;
    endsequence
    sequence high_wait_s;
        state == modulator_pkg::wait_high_fall && !modulation && high_ctrl.sync;
    endsequence

    low_sync_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (low_wait_s and (clk_en && !low_fall)) |=> state == modulator_pkg::wait_low_fall)
        else $error("low carrier switch before falling edge");
    high_sync_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (high_wait_s and (clk_en && !high_fall)) |=> state == modulator_pkg::wait_high_fall)
        else $error("high carrier switch before falling edge");
    low_invert_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clk_en && state == modulator_pkg::use_low && !modulation
            && low_ctrl.select == modulator_pkg::select_pwm_first)
        |=> carrier_out == ($past(carrier_sources[modulator_pkg::select_pwm_first])
        ^ $past(low_ctrl.invert)))
        else $error("low carrier polarity wrong");
    carrier_bit4_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !low_ctrl.unused && !high_ctrl.unused)
        else $error("unimplemented carrier bit set");
    unused_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        low_ctrl.select >= modulator_pkg::select_none_first |-> !pick_source(low_ctrl.select,
        carrier_sources))
        else $error("unconnected select passes a signal");
    pin_disable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clk_en && low_ctrl.pin_disable && low_ctrl.select == modulator_pkg::select_pwm_first)
        |=> !source_pin_drive_allow[modulator_pkg::select_pwm_first])
        else $error("disabled low carrier pin still allowed");
    carrier_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clk_en && state == modulator_pkg::use_high && modulation) |=> carrier_out
        == $past(high_carrier))
        else $error("carrier output not following high carrier");
    immediate_switch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clk_en && state == modulator_pkg::use_low && modulation && !low_ctrl.sync)
        |=> state == modulator_pkg::use_high)
        else $error("unsynchronised switch delayed");
endmodule : modulator_carrier_select
`default_nettype wire

/* common/modulator_pkg.sv */
// package: register map, field layout and states of the carrier select block
`default_nettype none
package modulator_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [3:0] mod_control_offset = 4'h0;
    localparam logic [3:0] source_select_offset = 4'h4;
    localparam logic [3:0] high_carrier_offset = 4'h8;
    localparam logic [3:0] low_carrier_offset = 4'hc;
    // carrier control fields
    localparam int carrier_pin_disable_bit = 7;
    localparam int carrier_invert_bit = 6;
    localparam int carrier_sync_bit = 5;
    localparam logic [7:0] carrier_implemented_mask = 8'hef;
    // modulator control fields
    localparam int enable_bit = 7;
    localparam int output_invert_bit = 4;
    localparam int output_level_bit = 3;
    localparam int software_bit = 0;
    localparam logic [7:0] control_implemented_mask = 8'hf9;
    localparam logic [7:0] source_implemented_mask = 8'h8f;
    // power-on values are undefined; zero is used
    localparam logic [7:0] register_reset = 8'h00;
    // carrier select codes
    localparam logic [3:0] select_ground = 4'h0;
    localparam logic [3:0] select_pwm_first = 4'h4;
    localparam logic [3:0] select_pwm_last = 4'h7;
    localparam logic [3:0] select_none_first = 4'h8;

    typedef struct packed {
        logic pin_disable;
        logic invert;
        logic sync;
        logic unused;
        logic [3:0] select;
    } carrier_ctrl_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } reg_req_s;

    typedef enum logic [3:0] {
        use_low = 4'b0001,
        wait_low_fall = 4'b0010,
        use_high = 4'b0100,
        wait_high_fall = 4'b1000
    } carrier_state_e;
endpackage : modulator_pkg
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the modulator carrier select block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] ctl_a = modulator_pkg::mod_control_offset;
    localparam logic [3:0] src_a = modulator_pkg::source_select_offset;
    localparam logic [3:0] hi_a = modulator_pkg::high_carrier_offset;
    localparam logic [3:0] lo_a = modulator_pkg::low_carrier_offset;
    localparam logic [3:0] offs [4] = '{ctl_a, src_a, hi_a, lo_a};
    // control bit 3 is a read-only status, left out of readback
    localparam logic [7:0] masks [4] = '{modulator_pkg::control_implemented_mask & 8'hf7,
        modulator_pkg::source_implemented_mask, modulator_pkg::carrier_implemented_mask,
        modulator_pkg::carrier_implemented_mask};
    localparam int timeout_cycles = 5000;
    logic clk_sys, reset_n, clk_en, reg_write, reg_read, modulation_in;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [15:0] carrier_sources, source_pin_drive_allow;
    logic carrier_out, modulated_out;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    int lreg, hreg, ctl, exp_allow;

    modulator_carrier_select dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .carrier_sources(carrier_sources),
        .modulation_in(modulation_in), .carrier_out(carrier_out),
        .modulated_out(modulated_out), .source_pin_drive_allow(source_pin_drive_allow)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == timeout_cycles) begin
            failures++;
            final_report();
        end
    end

    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    task automatic note(input logic bad, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (bad) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : note

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        note(got !== exp, 16'(got), 16'(exp));
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        note(got !== exp, 16'(got), 16'(exp));
    endtask : chk_bit

    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        note(got !== exp, got, exp);
    endtask : chk_pin

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr

    // read data stand one cycle only, then zero
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        chk_reg(reg_rdata & m, exp);
        @(posedge clk_sys);
        #1;
        chk_reg(reg_rdata, 8'h00);
    endtask : rd_chk

    // waits past any shortened pulse at a switch point
    task automatic settle();
        repeat (6) @(posedge clk_sys);
        #1;
    endtask : settle

    // model: code 1..7 picks a source, 0 and 8..15 give low, then invert
    task automatic check_out(input int r);
        logic e;
        settle();
        e = ((r[3:0] >= 1 && r[3:0] <= 7) ? carrier_sources[r[3:0]] : 1'b0) ^ r[6];
        chk_bit(carrier_out, e);
        chk_bit(modulated_out, ctl[7] & (e ^ ctl[4]));
    endtask : check_out

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        carrier_sources = 16'h0000;
        modulation_in = 1'b0;
        void'($urandom(32'hb5bd));
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        foreach (offs[i]) rd_chk(offs[i], masks[i], 8'h00);
        foreach (offs[i]) begin
            ctl = $urandom;
            wr(offs[i], ctl[7:0]);
            rd_chk(offs[i], (i == 0) ? 8'hf7 : 8'hff, ctl[7:0] & masks[i]);
        end
        wr(4'h2, 8'hff);
        rd_chk(4'h2, 8'hff, 8'h00);
        wr(src_a, 8'h01);
        for (int c = 0; c < 16; c++) begin
            lreg = ($urandom & 32'hc0) | c;
            hreg = ($urandom & 32'hc0) | (15 - c);
            ctl = $urandom & 32'h90;
            exp_allow = 32'hffff;
            if (lreg[7] && c >= 1 && c <= 7) exp_allow[c] = 1'b0;
            if (hreg[7] && 15 - c >= 1 && 15 - c <= 7) exp_allow[15 - c] = 1'b0;
            wr(lo_a, lreg[7:0]);
            wr(hi_a, hreg[7:0]);
            wr(ctl_a, ctl[7:0]);
            @(posedge clk_sys);
            carrier_sources <= 16'($urandom);
            modulation_in <= 1'b0;
            check_out(lreg);
            chk_pin(source_pin_drive_allow, exp_allow[15:0]);
            @(posedge clk_sys);
            modulation_in <= 1'b1;
            check_out(hreg);
        end
        wr(hi_a, 8'h04);
        wr(lo_a, 8'h25);
        wr(ctl_a, 8'h80);
        @(posedge clk_sys);
        carrier_sources <= 16'h0020;
        modulation_in <= 1'b0;
        settle();
        chk_bit(carrier_out, 1'b1);
        @(posedge clk_sys);
        modulation_in <= 1'b1;
        settle();
        chk_bit(carrier_out, 1'b1);
        @(posedge clk_sys);
        carrier_sources <= 16'h0010;
        settle();
        chk_bit(carrier_out, 1'b1);
        chk_bit(modulated_out, 1'b1);
        wr(hi_a, 8'h24);
        @(posedge clk_sys);
        modulation_in <= 1'b0;
        settle();
        chk_bit(carrier_out, 1'b1);
        @(posedge clk_sys);
        carrier_sources <= 16'h0020;
        settle();
        chk_bit(carrier_out, 1'b1);
        wr(lo_a, 8'h05);
        wr(hi_a, 8'h04);
        @(posedge clk_sys);
        modulation_in <= 1'b1;
        settle();
        chk_bit(carrier_out, 1'b0);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        carrier_sources <= 16'h0010;
        settle();
        chk_bit(carrier_out, 1'b0);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        settle();
        chk_bit(carrier_out, 1'b1);
        // software bit as modulation source, output level status readback
        wr(src_a, 8'h00);
        settle();
        chk_bit(carrier_out, 1'b0);
        wr(ctl_a, 8'h81);
        settle();
        chk_bit(carrier_out, 1'b1);
        rd_chk(ctl_a, 8'hff, 8'h89);
        final_report();
    end
endmodule : tb
`default_nettype wire
